// ===== verilog/twbesc_pkg.sv
// Constants, types and register map of the two-wire bus controller
package twbesc_pkg;

  localparam int unsigned WB_AW = 8;

  // Register indices; byte address is four times the index
  localparam logic [5:0] IDX_SERIAL_DATA = 6'h00;
  localparam logic [5:0] IDX_BUS_STATUS  = 6'h01;
  localparam logic [5:0] IDX_CTRL_STATUS = 6'h02;
  localparam logic [5:0] IDX_CONTROL_ONE = 6'h03;
  localparam logic [5:0] IDX_OWN_ADDRESS = 6'h04;
  localparam logic [5:0] IDX_CONTROL_TWO = 6'h05;
  localparam logic [5:0] IDX_PULLUP_CFG  = 6'h06;

  // Control status register bits
  localparam int unsigned CST_BUSY   = 0;
  localparam int unsigned CST_BB     = 1;
  localparam int unsigned CST_MATCH  = 2;
  localparam int unsigned CST_GCM    = 3;
  localparam int unsigned CST_SDA_LV = 4;

  // First control register bits
  localparam int unsigned C1_START   = 0;
  localparam int unsigned C1_STOP    = 1;
  localparam int unsigned C1_INTERRUPT_ENABLE_BIT   = 2;
  localparam int unsigned C1_NACK    = 3;
  localparam int unsigned C1_GENERAL_CALL_ENABLE   = 4;
  localparam int unsigned C1_NEW_MATCH_INTERRUPT_ENABLE  = 5;
  localparam int unsigned C1_SSTALL  = 6;

  // Own address, second control and pull-up register fields
  localparam int unsigned OA_EN      = 7;
  localparam int unsigned C2_ENABLE  = 0;
  localparam int unsigned PU_SDA     = 0;
  localparam int unsigned PU_SCL     = 1;

  // Reset values
  localparam logic [7:0] CTL1_RST    = 8'h00;
  localparam logic [7:0] OWN_RST     = 8'h00;
  localparam logic [7:0] CTL2_RST    = 8'h00;
  localparam logic [7:0] PULLUP_RST  = 8'h00;

  // Timing and bus constants
  localparam logic [6:0] MIN_HALF    = 7'h04;
  localparam logic [3:0] BIT_ACK     = 4'h8;
  localparam logic [3:0] BIT_LAST    = 4'h9;
  localparam logic [3:0] BIT_ILLEGAL = 4'h2;
  localparam logic [7:0] GC_ADDR     = 8'h00;

  typedef enum logic [3:0] {
    M_IDLE, M_START, M_HOLD, M_LOW, M_HIGH,
    M_RS_LOW, M_RS_HIGH, M_STOP_LOW, M_STOP_HIGH
  } twbesc_mst_t;

  typedef struct packed {
    logic slave_stop;
    logic data_buffer_status;
    logic bus_error_flag;
    logic neg_ack;
    logic stall_after_start;
    logic new_match_flag;
    logic master;
    logic transmit_direction_flag;
  } twbesc_status_t;

endpackage

// ===== verilog/twbesc_ctrl.sv
// Two-wire bus controller: error detection, slave mode, register file
//
// Decided for this implementation: the Wishbone interface to the registers.

// Overview of operation
// - Illegal start/stop or conflict: error, leave master
// - Failed start or restart sets bus error
// - Disable then enable resets bus logic and status; data register kept
// - Enabled and not master means slave
// - Compare own and general call address after start
// - Conflict: error, leave master, keep matching
// - Pull data low to acknowledge matched address
// - Match sets flags; transmit also sets buffer
// - Interrupt on new match when both enabled
// - Receiving slave holds acknowledge clock until data access
// - Slave stretches first clock while flags pending
// - Slave illegal start/stop: error, drop match
// - Open-drain lines with per-line pull-up enable
// - Master clock period from frequency field
// - Accept shorter high forced by other master
// - Write one clears, write zero keeps
// - Shift register, most significant bit first
// - Data write clears buffer flag; receive read too, start excepted
// - Status cleared on reset and disable
module twbesc_ctrl
  import twbesc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [WB_AW-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  input  wire logic             sda_i,
  output logic                  sda_o,
  output logic                  sda_oe_o,
  input  wire logic             scl_i,
  output logic                  scl_o,
  output logic                  scl_oe_o,
  output logic                  sda_pu_en_o,
  output logic                  scl_pu_en_o,
  output logic                  irq_o
);

  twbesc_status_t st_r;
  twbesc_mst_t    mst_r;
  twbesc_mst_t    mst_nxt;
  logic [7:0]     sd_r;
  logic [7:0]     ctl1_r;
  logic [7:0]     oa_r;
  logic [7:0]     ctl2_r;
  logic [7:0]     pu_r;
  logic [7:0]     rdata;
  logic [6:0]     hcnt_r;
  logic [6:0]     hcnt_nxt;
  logic [6:0]     half_c;
  logic [3:0]     cnt_r;
  logic           ack_r;
  logic           sda_m_r;
  logic           sda_s_r;
  logic           sda_d_r;
  logic           scl_m_r;
  logic           scl_s_r;
  logic           scl_d_r;
  logic           sda_oe_r;
  logic           scl_oe_r;
  logic           addr_ph_r;
  logic           mst_addr_r;
  logic           match_r;
  logic           gcm_r;
  logic           bus_busy_flag_r;
  logic           slv_nack_r;
  logic           ack_smp_r;
  logic           irq_r;
  logic           clr;
  logic           start_ev;
  logic           stop_ev;
  logic           rise_ev;
  logic           fall_ev;
  logic           illegal;
  logic           hdone;
  logic           own_hit;
  logic           gc_hit;
  logic           slave_act;
  logic           mst_run;
  logic           tx_c;
  logic           m_lost;
  logic           drive_low_c;
  logic           stall_c;
  logic           ev_start_ok;
  logic           ev_fail;
  logic           ev_byte_end;
  logic           ev_stop_done;
  logic           wr;
  logic           rd;
  logic [5:0]     idx;

  // Register bus access, applied on the acknowledge cycle
  assign idx = adr_i[7:2];
  assign wr  = cyc_i & stb_i & ack_r & we_i & sel_i[0];
  assign rd  = cyc_i & stb_i & ack_r & ~we_i;
  assign clr = rst_i | ~ctl2_r[C2_ENABLE];

  // Line synchronisers and edge finders
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sda_m_r <= 1'b1;
      sda_s_r <= 1'b1;
      sda_d_r <= 1'b1;
      scl_m_r <= 1'b1;
      scl_s_r <= 1'b1;
      scl_d_r <= 1'b1;
    end else begin
      sda_m_r <= sda_i;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      scl_m_r <= scl_i;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
    end
  end

  assign start_ev = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r;
  assign stop_ev  = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r;
  assign rise_ev  = scl_s_r & ~scl_d_r;
  assign fall_ev  = ~scl_s_r & scl_d_r;
  assign illegal  = (start_ev | stop_ev) & (cnt_r >= BIT_ILLEGAL);

  // Bit position within the current byte
  always_ff @(posedge clk_i) begin
    if (clr) begin
      cnt_r     <= 4'h0;
      addr_ph_r <= 1'b0;
      ack_smp_r <= 1'b1;
    end else begin
      if (start_ev) begin
        cnt_r     <= 4'h0;
        addr_ph_r <= 1'b1;
      end else if (stop_ev) begin
        cnt_r     <= 4'h0;
        addr_ph_r <= 1'b0;
      end else if (rise_ev) begin
        cnt_r <= 4'(cnt_r + 4'h1);
      end else if (fall_ev && cnt_r == BIT_LAST) begin
        cnt_r     <= 4'h0;
        addr_ph_r <= 1'b0;
      end
      if (rise_ev && cnt_r == BIT_ACK) begin
        ack_smp_r <= sda_s_r;
      end
    end
  end

  // Serial data shift register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sd_r <= 8'h00;
    end else if (wr && idx == IDX_SERIAL_DATA) begin
      sd_r <= dat_i[7:0];
    end else if (rise_ev && cnt_r < BIT_ACK) begin
      sd_r <= {sd_r[6:0], sda_s_r};
    end
  end

  // Address compare, also while master
  assign own_hit   = addr_ph_r & oa_r[OA_EN] &
                     (sd_r[7:1] == oa_r[6:0]);
  assign gc_hit    = addr_ph_r & ctl1_r[C1_GENERAL_CALL_ENABLE] &
                     (sd_r == GC_ADDR);
  assign slave_act = (match_r | gcm_r) & ~st_r.master;
  assign mst_run   = st_r.master &
                     (mst_r == M_HOLD || mst_r == M_LOW || mst_r == M_HIGH);
  assign tx_c      = mst_addr_r | st_r.transmit_direction_flag;
  assign m_lost    = rise_ev & mst_run & tx_c & (cnt_r < BIT_ACK) &
                     ~sda_oe_r & ~sda_s_r;

  // Master clock half period
  assign half_c = (ctl2_r[7:1] < MIN_HALF) ? MIN_HALF : ctl2_r[7:1];
  assign hdone  = hcnt_r >= 7'(half_c - 7'h01);

  always_comb begin
    mst_nxt      = mst_r;
    hcnt_nxt     = 7'(hcnt_r + 7'h01);
    ev_start_ok  = 1'b0;
    ev_fail      = 1'b0;
    ev_byte_end  = 1'b0;
    ev_stop_done = 1'b0;
    unique case (mst_r)
      M_IDLE: begin
        hcnt_nxt = 7'h00;
        if (ctl1_r[C1_START] & ~bus_busy_flag_r & scl_s_r & sda_s_r) begin
          mst_nxt = M_START;
        end
      end
      M_START: begin
        if (~scl_s_r) begin
          ev_fail = 1'b1;
          mst_nxt = M_IDLE;
        end else if (hdone) begin
          ev_start_ok = 1'b1;
          mst_nxt     = M_HOLD;
          hcnt_nxt    = 7'h00;
        end
      end
      M_HOLD: begin
        hcnt_nxt = 7'h00;
        if (~st_r.master) begin
          mst_nxt = M_IDLE;
        end else if (ctl1_r[C1_STOP]) begin
          mst_nxt = M_STOP_LOW;
        end else if (ctl1_r[C1_START]) begin
          mst_nxt = M_RS_LOW;
        end else if (~(st_r.data_buffer_status | st_r.neg_ack |
                       st_r.stall_after_start)) begin
          mst_nxt = M_LOW;
        end
      end
      M_LOW: begin
        if (~st_r.master) begin
          mst_nxt = M_IDLE;
        end else if (hdone) begin
          mst_nxt  = M_HIGH;
          hcnt_nxt = 7'h00;
        end
      end
      M_HIGH: begin
        if (~scl_s_r) begin
          hcnt_nxt = hcnt_r;
        end
        if (~st_r.master | m_lost) begin
          mst_nxt = M_IDLE;
        end else if ((scl_s_r & hdone) |
                     (~scl_s_r & (hcnt_r != 7'h00))) begin
          hcnt_nxt = 7'h00;
          if (cnt_r == BIT_LAST) begin
            ev_byte_end = 1'b1;
            mst_nxt     = M_HOLD;
          end else begin
            mst_nxt = M_LOW;
          end
        end
      end
      M_RS_LOW: begin
        if (hdone) begin
          mst_nxt  = M_RS_HIGH;
          hcnt_nxt = 7'h00;
        end
      end
      M_RS_HIGH: begin
        if (~scl_s_r) begin
          hcnt_nxt = hcnt_r;
        end else if (hdone) begin
          hcnt_nxt = 7'h00;
          if (~sda_s_r) begin
            ev_fail = 1'b1;
            mst_nxt = M_IDLE;
          end else begin
            mst_nxt = M_START;
          end
        end
      end
      M_STOP_LOW: begin
        if (hdone) begin
          mst_nxt  = M_STOP_HIGH;
          hcnt_nxt = 7'h00;
        end
      end
      M_STOP_HIGH: begin
        if (~scl_s_r) begin
          hcnt_nxt = hcnt_r;
        end else if (hdone) begin
          ev_stop_done = 1'b1;
          mst_nxt      = M_IDLE;
        end
      end
      default: begin
        mst_nxt = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (clr) begin
      mst_r      <= M_IDLE;
      hcnt_r     <= 7'h00;
      mst_addr_r <= 1'b0;
    end else begin
      mst_r  <= mst_nxt;
      hcnt_r <= hcnt_nxt;
      if (ev_start_ok) begin
        mst_addr_r <= 1'b1;
      end else if (ev_byte_end | ev_fail | m_lost) begin
        mst_addr_r <= 1'b0;
      end
    end
  end

  // Status flags; hardware sets are placed after software clears
  always_ff @(posedge clk_i) begin
    if (clr) begin
      st_r            <= '0;
      match_r         <= 1'b0;
      gcm_r           <= 1'b0;
      bus_busy_flag_r <= 1'b0;
      slv_nack_r      <= 1'b0;
    end else begin
      if (wr && idx == IDX_BUS_STATUS) begin
        if (dat_i[7]) st_r.slave_stop        <= 1'b0;
        if (dat_i[5]) st_r.bus_error_flag    <= 1'b0;
        if (dat_i[4]) st_r.neg_ack           <= 1'b0;
        if (dat_i[3]) st_r.stall_after_start <= 1'b0;
        if (dat_i[2]) st_r.new_match_flag    <= 1'b0;
      end
      if (wr && idx == IDX_CTRL_STATUS && dat_i[CST_BB]) begin
        bus_busy_flag_r <= 1'b0;
      end
      if (wr && idx == IDX_SERIAL_DATA) begin
        st_r.data_buffer_status <= 1'b0;
      end
      if (rd && idx == IDX_SERIAL_DATA && ~ctl1_r[C1_START] &&
          ~st_r.transmit_direction_flag) begin
        st_r.data_buffer_status <= 1'b0;
      end
      if (ev_start_ok) begin
        st_r.master             <= 1'b1;
        st_r.data_buffer_status <= 1'b1;
      end
      if (ev_byte_end) begin
        if (ack_smp_r && tx_c) begin
          st_r.neg_ack <= 1'b1;
        end else if (mst_addr_r) begin
          st_r.transmit_direction_flag <= ~sd_r[0];
          if (ctl1_r[C1_SSTALL]) begin
            st_r.stall_after_start <= 1'b1;
          end else if (~sd_r[0]) begin
            st_r.data_buffer_status <= 1'b1;
          end
        end else begin
          st_r.data_buffer_status <= 1'b1;
        end
      end
      if (ev_fail | m_lost) begin
        st_r.bus_error_flag <= 1'b1;
        st_r.master         <= 1'b0;
      end
      if (fall_ev && cnt_r == BIT_ACK && (own_hit | gc_hit)) begin
        match_r                      <= 1'b1;
        gcm_r                        <= gc_hit;
        st_r.new_match_flag          <= 1'b1;
        slv_nack_r                   <= 1'b0;
        if (~st_r.master) begin
          st_r.transmit_direction_flag <= sd_r[0];
          if (sd_r[0]) begin
            st_r.data_buffer_status <= 1'b1;
          end
        end
      end
      if (fall_ev && cnt_r == BIT_ACK && ~addr_ph_r && slave_act &&
          ~st_r.transmit_direction_flag) begin
        st_r.data_buffer_status <= 1'b1;
      end
      if (rise_ev && cnt_r == BIT_ACK && slave_act &&
          st_r.transmit_direction_flag) begin
        if (sda_s_r) begin
          slv_nack_r <= 1'b1;
        end else begin
          st_r.data_buffer_status <= 1'b1;
        end
      end
      if (start_ev) begin
        bus_busy_flag_r <= 1'b1;
        match_r         <= 1'b0;
        gcm_r           <= 1'b0;
      end
      if (stop_ev) begin
        bus_busy_flag_r <= 1'b0;
        if (match_r | gcm_r) begin
          st_r.slave_stop <= 1'b1;
        end
        match_r                      <= 1'b0;
        gcm_r                        <= 1'b0;
        st_r.master                  <= 1'b0;
        st_r.transmit_direction_flag <= 1'b0;
      end
      if (illegal) begin
        st_r.bus_error_flag <= 1'b1;
        st_r.master         <= 1'b0;
        match_r             <= 1'b0;
        gcm_r               <= 1'b0;
      end
    end
  end

  // Data line value to present while the clock is low
  always_comb begin
    drive_low_c = 1'b0;
    if (mst_run) begin
      if (cnt_r < BIT_ACK) begin
        drive_low_c = tx_c & ~sd_r[7];
      end else if (cnt_r == BIT_ACK) begin
        drive_low_c = ~tx_c & ~ctl1_r[C1_NACK];
      end
    end else if (cnt_r == BIT_ACK && addr_ph_r) begin
      drive_low_c = own_hit | gc_hit;
    end else if (slave_act) begin
      if (cnt_r < BIT_ACK) begin
        drive_low_c = st_r.transmit_direction_flag & ~slv_nack_r &
                      ~sd_r[7];
      end else if (cnt_r == BIT_ACK) begin
        drive_low_c = ~st_r.transmit_direction_flag;
      end
    end
  end

  // Slave clock stretch
  assign stall_c = slave_act & ~scl_s_r &
                   (((cnt_r == 4'h0) & ~addr_ph_r &
                     (st_r.data_buffer_status |
                      (st_r.new_match_flag & ctl1_r[C1_NEW_MATCH_INTERRUPT_ENABLE]))) |
                    ((cnt_r == BIT_ACK) & ~addr_ph_r &
                     ~st_r.transmit_direction_flag &
                     st_r.data_buffer_status));

  // Open-drain line drivers
  always_ff @(posedge clk_i) begin
    if (clr) begin
      sda_oe_r <= 1'b0;
      scl_oe_r <= 1'b0;
    end else begin
      scl_oe_r <= (mst_nxt == M_HOLD) || (mst_nxt == M_LOW) ||
                  (mst_nxt == M_RS_LOW) || (mst_nxt == M_STOP_LOW) ||
                  stall_c;
      unique case (mst_nxt)
        M_START, M_STOP_LOW, M_STOP_HIGH: sda_oe_r <= 1'b1;
        M_RS_LOW, M_RS_HIGH:              sda_oe_r <= 1'b0;
        default: begin
          if (~scl_s_r) begin
            sda_oe_r <= drive_low_c;
          end else if (ev_stop_done) begin
            sda_oe_r <= 1'b0;
          end
        end
      endcase
    end
  end

  assign sda_o       = 1'b0;
  assign scl_o       = 1'b0;
  assign sda_oe_o    = sda_oe_r;
  assign scl_oe_o    = scl_oe_r;
  assign sda_pu_en_o = pu_r[PU_SDA];
  assign scl_pu_en_o = pu_r[PU_SCL];

  // Control registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl1_r <= CTL1_RST;
      oa_r   <= OWN_RST;
      ctl2_r <= CTL2_RST;
      pu_r   <= PULLUP_RST;
    end else begin
      if (wr && idx == IDX_CONTROL_ONE) ctl1_r <= dat_i[7:0];
      if (wr && idx == IDX_OWN_ADDRESS) oa_r   <= dat_i[7:0];
      if (wr && idx == IDX_CONTROL_TWO) ctl2_r <= dat_i[7:0];
      if (wr && idx == IDX_PULLUP_CFG)  pu_r   <= dat_i[7:0];
      if (ev_start_ok | ev_fail | ~ctl2_r[C2_ENABLE]) begin
        ctl1_r[C1_START] <= 1'b0;
      end
      if (ev_stop_done | ~ctl2_r[C2_ENABLE]) begin
        ctl1_r[C1_STOP] <= 1'b0;
      end
    end
  end

  // Read data selection
  always_comb begin
    rdata = 8'h00;
    unique case (idx)
      IDX_SERIAL_DATA: rdata = sd_r;
      IDX_BUS_STATUS:  rdata = st_r;
      IDX_CTRL_STATUS: rdata = {3'b000, sda_s_r, gcm_r, match_r,
                                bus_busy_flag_r,
                                st_r.master | match_r | gcm_r};
      IDX_CONTROL_ONE: rdata = ctl1_r;
      IDX_OWN_ADDRESS: rdata = oa_r;
      IDX_CONTROL_TWO: rdata = ctl2_r;
      IDX_PULLUP_CFG:  rdata = pu_r;
      default:         rdata = 8'h00;
    endcase
  end

  // Wishbone slave: answer one cycle after the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_r <= cyc_i & stb_i & ~ack_r;
      if (cyc_i & stb_i & ~ack_r) begin
        dat_o <= {24'h00_0000, rdata};
      end
    end
  end

  assign ack_o = ack_r;

  // Interrupt request
  always_ff @(posedge clk_i) begin
    if (clr) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctl1_r[C1_INTERRUPT_ENABLE_BIT] &
               ((st_r.new_match_flag & ctl1_r[C1_NEW_MATCH_INTERRUPT_ENABLE]) |
                st_r.bus_error_flag | st_r.neg_ack |
                st_r.stall_after_start | st_r.data_buffer_status);
    end
  end

  assign irq_o = irq_r;

endmodule

// ===== test/twbesc_sva.sv
// Port assertions for the two-wire bus controller
module twbesc_sva
  import twbesc_pkg::*;
(
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [WB_AW-1:0] adr_i,
  input wire logic [31:0]      dat_o,
  input wire logic             ack_o,
  input wire logic             sda_o,
  input wire logic             sda_oe_o,
  input wire logic             scl_o,
  input wire logic             scl_oe_o,
  input wire logic             sda_pu_en_o,
  input wire logic             scl_pu_en_o
);
  logic pu_wr;

  assign pu_wr = ack_o && we_i && adr_i[7:2] == IDX_PULLUP_CFG;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  bus_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("request not acked");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack too long");
  ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
    else $error("ack without request");
  dat_hold_a: assert property (!ack_o |-> $stable(dat_o))
    else $error("read data moved");
  dat_upper_a: assert property (ack_o |-> dat_o[31:8] == 24'h000000)
    else $error("upper read data set");
  open_drain_a: assert property (!sda_o && !scl_o)
    else $error("line driven high");
  quiet_out_a: assert property ($fell(rst_i) |->
    !ack_o && !sda_oe_o && !scl_oe_o && !sda_pu_en_o && !scl_pu_en_o)
    else $error("outputs busy after reset");
  pullup_wr_a: assert property ($changed({sda_pu_en_o, scl_pu_en_o}) |->
    $past(pu_wr) || $past(pu_wr, 2))
    else $error("pull-up changed without write");
endmodule

bind twbesc_ctrl twbesc_sva u_sva (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_pu_en_o(sda_pu_en_o),
  .scl_pu_en_o(scl_pu_en_o)
);

// ===== test/twbesc_bus_model.sv
// Behavioural master on the two-wire bus
module twbesc_bus_model (
  input  wire logic sda_i,
  input  wire logic scl_i,
  output logic      sda_oe_o,
  output logic      scl_oe_o,
  output logic      tmo_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sda_oe_o = 1'h0;
    scl_oe_o = 1'h0;
    tmo_o = 1'h0;
  end

  // Release clock, wait out any stretch
  task automatic rise();
    int n;
    scl_oe_o = 1'h0;
    n = 0;
    while (scl_i !== 1'h1 && n < 5000) begin
      #10;
      n++;
    end
    if (n == 5000) tmo_o = 1'h1;
    #40;
  endtask

  task automatic bit_c(input logic b, output logic r);
    #20 sda_oe_o = ~b;
    #20 rise();
    r = sda_i;
    scl_oe_o = 1'h1;
  endtask

  // Offset keeps line changes off the core clock edges
  task automatic start_c();
    #3 sda_oe_o = 1'h1;
    #40 scl_oe_o = 1'h1;
  endtask

  task automatic stop_c();
    #20 sda_oe_o = 1'h1;
    #20 rise();
    sda_oe_o = 1'h0;
    #40;
  endtask

  task automatic xact(input logic [7:0] a, d, output logic [7:0] q,
                      output logic aa, da);
    logic [7:0] x;
    start_c();
    for (int i = 7; i >= 0; i--) bit_c(a[i], x[i]);
    bit_c(1'h1, aa);
    for (int i = 7; i >= 0; i--) bit_c(d[i], q[i]);
    bit_c(1'h1, da);
    stop_c();
  endtask

  // Stop after three data bits
  task automatic bad(input logic [7:0] a);
    logic r;
    start_c();
    for (int i = 7; i >= 0; i--) bit_c(a[i], r);
    bit_c(1'h1, r);
    for (int i = 0; i < 3; i++) bit_c(1'h0, r);
    stop_c();
  endtask
endmodule

// ===== test/tb.sv
// Testbench: register access and two-wire bus scenarios
module tb
  import twbesc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rst, cyc, stb, we, ack, irq, tmo, aa, da;
  logic        sda_oe, scl_oe, spu, cpu, m_sda, m_scl;
  logic [7:0]  adr, q, rq;
  logic [31:0] wdat, rdat;
  int          err_count, n_tests;
  localparam int RECOVERY_WAIT = 200;
  wire         sda_w = !(sda_oe || m_sda);
  wire         scl_w = !(scl_oe || m_scl);

  twbesc_ctrl uut (
    .clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(4'h1), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
    .sda_i(sda_w), .sda_o(), .sda_oe_o(sda_oe), .scl_i(scl_w), .scl_o(),
    .scl_oe_o(scl_oe), .sda_pu_en_o(spu), .scl_pu_en_o(cpu), .irq_o(irq)
  );
  twbesc_bus_model bm (
    .sda_i(sda_w), .scl_i(scl_w), .sda_oe_o(m_sda), .scl_oe_o(m_scl),
    .tmo_o(tmo)
  );

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= {i, 2'h0};
    wdat <= {24'h000000, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'h1 && n < 20);
    q = rdat[7:0];
    cyc <= 1'h0;
    stb <= 1'h0;
    if (n == 20) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic rd(input logic [5:0] i);
    wb(1'h0, i, 8'h00);
  endtask

  task automatic wr(input logic [5:0] i, input logic [7:0] d);
    wb(1'h1, i, d);
  endtask

  task automatic poll(input int b);
    int n;
    n = 0;
    do begin
      rd(IDX_BUS_STATUS);
      n++;
    end while (q[b] !== 1'h1 && n < 500);
    if (n == 500) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic hold_chk();
    int n;
    n = 0;
    while (scl_oe !== 1'h1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(scl_oe, 1'h1);
  endtask

  task automatic slave_rx(input logic [7:0] a, d);
    fork
      bm.xact(a, d, rq, aa, da);
      begin
        poll(2);
        hold_chk();
        chk(irq, 1'h1);
        rd(IDX_CTRL_STATUS);
        chk(q[3:1], {a == 8'h00, 2'h3});
        wr(IDX_BUS_STATUS, 8'h04);
        poll(6);
        hold_chk();
        rd(IDX_SERIAL_DATA);
        chk(q, d);
      end
    join
    chk(aa, 1'h0);
    rd(IDX_CTRL_STATUS);
    chk(q[1], 1'h0);
  endtask

  initial begin
    rst = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h00;
    wdat = 32'h00000000;
    err_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 8; i++) begin
      rd(i[5:0]);
      chk(q, (i == 2) ? 8'h10 : 8'h00);
    end
    wr(IDX_PULLUP_CFG, 8'h03);
    @(posedge clk);
    chk({6'h00, spu, cpu}, 8'h03);
    $display("Test reset and pull-ups done");
    wr(IDX_OWN_ADDRESS, 8'hAA);
    wr(IDX_CONTROL_ONE, 8'h34);
    wr(IDX_CONTROL_TWO, 8'h01);
    slave_rx(8'h54, 8'hC3);
    rd(IDX_BUS_STATUS);
    chk(q, 8'h80);
    wr(IDX_BUS_STATUS, 8'h00);
    rd(IDX_BUS_STATUS);
    chk(q, 8'h80);
    wr(IDX_BUS_STATUS, 8'h80);
    rd(IDX_BUS_STATUS);
    chk(q, 8'h00);
    slave_rx(8'h00, 8'h3C);
    wr(IDX_BUS_STATUS, 8'hFF);
    $display("Test slave receive done");
    fork
      bm.xact(8'h55, 8'hFF, rq, aa, da);
      begin
        poll(6);
        hold_chk();
        rd(IDX_BUS_STATUS);
        chk(q, 8'h45);
        wr(IDX_BUS_STATUS, 8'h04);
        wr(IDX_SERIAL_DATA, 8'h96);
      end
    join
    chk(rq, 8'h96);
    $display("Test slave transmit done");
    fork
      bm.bad(8'h54);
      begin
        poll(2);
        wr(IDX_BUS_STATUS, 8'h04);
      end
    join
    rd(IDX_BUS_STATUS);
    chk(q[5], 1'h1);
    rd(IDX_CTRL_STATUS);
    chk(q[3:2], 2'h0);
    wr(IDX_BUS_STATUS, 8'h20);
    wr(IDX_CTRL_STATUS, 8'h02);
    repeat (RECOVERY_WAIT) @(posedge clk);
    rd(IDX_CTRL_STATUS);
    chk(q[1], 1'h0);
    wr(IDX_CONTROL_TWO, 8'h00);
    rd(IDX_BUS_STATUS);
    chk(q, 8'h00);
    wr(IDX_CONTROL_TWO, 8'h01);
    bm.xact(8'h30, 8'h11, rq, aa, da);
    chk(aa, 1'h1);
    wr(IDX_CONTROL_ONE, 8'h35);
    poll(6);
    wr(IDX_SERIAL_DATA, 8'h30);
    poll(4);
    wr(IDX_CONTROL_ONE, 8'h36);
    repeat (40) @(posedge clk);
    rd(IDX_BUS_STATUS);
    chk(q, 8'h10);
    rd(IDX_CTRL_STATUS);
    chk(q[1:0], 2'h0);
    chk(sda_oe, 1'h0);
    chk(tmo, 1'h0);
    $display("Test bus error and re-enable done");
    report_and_stop();
  end
endmodule
